// File: rtl/rtcal_pkg.sv
// Constants for the real-time clock, alarm and calibration block.
// Assumes a 125 MHz system clock with a one-cycle time base enable.
//
// Summary of operation
// - Keepalive set keeps secure clock driver on
// - Keepalive clear drops secure clock when off
// - Secure regulator enabled from reset, never disabled
// - Mode codes 00110..01001 (bit 4 clear) give 1.3 V when on
// - Other mode codes always give 1.2 V
// - Disable bit stops clock; enabled after power-up
// - Prescaler divides time base to one-second tick
// - Seconds counter runs 0 to 86399 then wraps
// - Seconds wrap increments 15-bit day counter
// - Tick sets flag; interrupt only when unmasked
// - Seconds and day match set alarm flag
// - Alarm turns system on when off
// - Reset clears counters and alarm registers
// - Reset sets the time lost flag
// - 5-bit signed word adjusts prescaler length
// - Word value equals counts per 32768 cycles
// - Calibration touches prescaler only, not clocks
// - Mode 00 off, 01 not coin, 11 all
// - Mode 01 suspends on backup cell power
// - Flags latched until written one; mask blocks
// - All mask bits set at power-up
package rtcal_pkg;

    //------------------------------------------------------------
    // Widths and counts
    //------------------------------------------------------------
    localparam int SEC_W = 17;
    localparam int DAY_W = 15;
    localparam int PRE_W = 16;
    localparam int CAL_W = 5;
    localparam int FLAG_W = 3;
    localparam logic [PRE_W-1:0] PRE_NOMINAL = 16'h8000;
    localparam logic [SEC_W-1:0] SEC_LAST = 17'h1_517F;

    //------------------------------------------------------------
    // Flag positions, reset values, mode encodings
    //------------------------------------------------------------
    localparam int FLAG_TICK = 0;
    localparam int FLAG_ALARM = 1;
    localparam int FLAG_LOST = 2;
    localparam logic [FLAG_W-1:0] MASK_RESET = 3'h7;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h4;
    localparam logic [1:0] CALMODE_OFF = 2'h0;
    localparam logic [1:0] CALMODE_NOCOIN = 2'h1;
    localparam logic [1:0] CALMODE_ALL = 2'h3;
    localparam logic [3:0] PUMS_HI_FIRST = 4'h6;
    localparam logic [3:0] PUMS_HI_LAST = 4'h9;

    // Operating states seen by the block
    typedef enum logic [1:0] {
        RTCAL_ON,
        RTCAL_STANDBY,
        RTCAL_OFF,
        RTCAL_COIN
    } rtcal_pwr_t;

endpackage

// File: rtl/rtcal_prescaler.sv
// Calibrated prescaler producing the one-second tick.
// Assumes tb_en_i pulses once per 32.768 kHz time base cycle.
`timescale 1ns/1ps
module rtcal_prescaler
(
    input  wire logic                          clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          run_i,
    input  wire logic                          tb_en_i,
    input  wire logic                          cal_on_i,
    input  wire logic [rtcal_pkg::CAL_W-1:0]   cal_word_i,
    output logic                               tick_o
);

    logic [rtcal_pkg::PRE_W-1:0] cnt_reg;
    logic [rtcal_pkg::PRE_W-1:0] cnt_next;
    logic [rtcal_pkg::PRE_W-1:0] period;
    logic [rtcal_pkg::PRE_W-1:0] cal_ext;
    logic                        tick_next;
    logic                        tick_reg;

    //------------------------------------------------------------
    // Period length
    //------------------------------------------------------------
    // Sign-extend word; negative shortens, positive lengthens
    always_comb
    begin
        cal_ext = {{(rtcal_pkg::PRE_W-rtcal_pkg::CAL_W){cal_word_i[4]}},
                   cal_word_i};
        period = cal_on_i ? rtcal_pkg::PRE_NOMINAL + cal_ext
                          : rtcal_pkg::PRE_NOMINAL;
    end

    // Count time base enables, wrap at period end
    always_comb
    begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (run_i && tb_en_i)
        begin
            if (cnt_reg >= period - 16'h0001)
            begin
                cnt_next = '0;
                tick_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    // Register prescaler state
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule

// File: rtl/rtcal_top.sv
// Real-time clock: time and day counters, alarm, calibration,
// flags, secure clock keepalive and regulator level select.
// Assumes reset_n_i is the backup power-on reset and all inputs
// are synchronous to clk_i; host writes arrive as one-cycle pulses.
`timescale 1ns/1ps
module rtcal_top
(
    input  wire logic                          clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          tb_en_i,
    input  wire logic                          ref_clock_i,
    input  wire logic [1:0]                    pwr_state_i,
    input  wire logic [4:0]                    power_up_mode_select_i,
    input  wire logic                          secure_clock_keepalive_i,
    input  wire logic                          clock_disable_bit_i,
    input  wire logic [rtcal_pkg::CAL_W-1:0]   calibration_word_i,
    input  wire logic [1:0]                    calibration_enable_mode_i,
    input  wire logic                          alarm_wr_i,
    input  wire logic [rtcal_pkg::SEC_W-1:0]   alarm_sec_wdata_i,
    input  wire logic [rtcal_pkg::DAY_W-1:0]   alarm_day_wdata_i,
    input  wire logic                          time_wr_i,
    input  wire logic [rtcal_pkg::SEC_W-1:0]   sec_wdata_i,
    input  wire logic [rtcal_pkg::DAY_W-1:0]   day_wdata_i,
    input  wire logic                          mask_wr_i,
    input  wire logic [rtcal_pkg::FLAG_W-1:0]  mask_wdata_i,
    input  wire logic [rtcal_pkg::FLAG_W-1:0]  flag_clear_i,
    output logic [rtcal_pkg::SEC_W-1:0]        seconds_of_day_o,
    output logic [rtcal_pkg::DAY_W-1:0]        day_count_o,
    output logic [rtcal_pkg::SEC_W-1:0]        alarm_seconds_o,
    output logic [rtcal_pkg::DAY_W-1:0]        alarm_day_o,
    output logic [rtcal_pkg::FLAG_W-1:0]       flags_o,
    output logic [rtcal_pkg::FLAG_W-1:0]       mask_o,
    output logic                               irq_o,
    output logic                               alarm_wake_o,
    output logic                               secure_ref_clock_out_o,
    output logic                               secure_ref_clock_en_o,
    output logic                               secure_domain_reg_en_o,
    output logic                               secure_domain_reg_hi_o
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    logic [rtcal_pkg::SEC_W-1:0]  sec_reg;
    logic [rtcal_pkg::SEC_W-1:0]  sec_next;
    logic [rtcal_pkg::DAY_W-1:0]  day_reg;
    logic [rtcal_pkg::DAY_W-1:0]  day_next;
    logic [rtcal_pkg::SEC_W-1:0]  alarm_sec_reg;
    logic [rtcal_pkg::SEC_W-1:0]  alarm_sec_next;
    logic [rtcal_pkg::DAY_W-1:0]  alarm_day_reg;
    logic [rtcal_pkg::DAY_W-1:0]  alarm_day_next;
    logic [rtcal_pkg::FLAG_W-1:0] flag_reg;
    logic [rtcal_pkg::FLAG_W-1:0] flag_next;
    logic [rtcal_pkg::FLAG_W-1:0] mask_reg;
    logic [rtcal_pkg::FLAG_W-1:0] mask_next;
    logic [rtcal_pkg::FLAG_W-1:0] flag_set;
    logic                         match_reg;
    logic                         match_next;
    logic                         wake_reg;
    logic                         wake_next;
    logic                         sec_en_reg;
    logic                         sec_en_next;
    logic                         hi_reg;
    logic                         hi_next;
    logic                         tick;
    logic                         cal_on;
    logic                         run;
    logic                         is_off;
    logic                         is_on;
    logic                         pums_hi;
    logic                         match_now;
    rtcal_pkg::rtcal_pwr_t        pwr_state;

    //------------------------------------------------------------
    // Power state decode and calibration enable
    //------------------------------------------------------------
    // Decode power state and calibration qualifiers
    always_comb
    begin
        pwr_state = rtcal_pkg::rtcal_pwr_t'(pwr_state_i);
        is_off = (pwr_state == rtcal_pkg::RTCAL_OFF)
              || (pwr_state == rtcal_pkg::RTCAL_COIN);
        is_on = !is_off;
        run = !clock_disable_bit_i;
        unique case (calibration_enable_mode_i)
            rtcal_pkg::CALMODE_NOCOIN:
                cal_on = (pwr_state != rtcal_pkg::RTCAL_COIN);
            rtcal_pkg::CALMODE_ALL:
                cal_on = 1'b1;
            default:
                cal_on = 1'b0; // Off or reserved code
        endcase
    end

    //------------------------------------------------------------
    // Prescaler
    //------------------------------------------------------------
    rtcal_prescaler u_prescaler
    (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .run_i      (run),
        .tb_en_i    (tb_en_i),
        .cal_on_i   (cal_on),
        .cal_word_i (calibration_word_i),
        .tick_o     (tick)
    );

    //------------------------------------------------------------
    // Time and day counters
    //------------------------------------------------------------
    // Advance on tick, wrap seconds, carry into day
    always_comb
    begin
        sec_next = sec_reg;
        day_next = day_reg;
        if (time_wr_i)
        begin
            sec_next = sec_wdata_i;
            day_next = day_wdata_i;
        end
        else if (tick)
        begin
            if (sec_reg >= rtcal_pkg::SEC_LAST)
            begin
                sec_next = '0;
                day_next = day_reg + 15'h0001;
            end
            else
            begin
                sec_next = sec_reg + 17'h0_0001;
            end
        end
    end

    // Counters cleared by backup reset
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sec_reg <= '0;
            day_reg <= '0;
        end
        else
        begin
            sec_reg <= sec_next;
            day_reg <= day_next;
        end
    end

    //------------------------------------------------------------
    // Alarm registers and match
    //------------------------------------------------------------
    // Host loads alarm time; match detected on rising edge only
    always_comb
    begin
        alarm_sec_next = alarm_wr_i ? alarm_sec_wdata_i : alarm_sec_reg;
        alarm_day_next = alarm_wr_i ? alarm_day_wdata_i : alarm_day_reg;
        match_now = (sec_reg == alarm_sec_reg)
                 && (day_reg == alarm_day_reg);
        match_next = match_now;
        sec_en_next = sec_en_reg;
        if (time_wr_i || alarm_wr_i || tick)
            sec_en_next = 1'b1;
    end

    // Register alarm state
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            alarm_sec_reg <= '0;
            alarm_day_reg <= '0;
            match_reg <= 1'b1;
            sec_en_reg <= 1'b0;
        end
        else
        begin
            alarm_sec_reg <= alarm_sec_next;
            alarm_day_reg <= alarm_day_next;
            match_reg <= match_next;
            sec_en_reg <= sec_en_next;
        end
    end

    //------------------------------------------------------------
    // Flags and masks
    //------------------------------------------------------------
    // Hardware set wins over a write-one clear
    always_comb
    begin
        flag_set = '0;
        flag_set[rtcal_pkg::FLAG_TICK] = tick;
        flag_set[rtcal_pkg::FLAG_ALARM] = match_now && !match_reg
                                       && sec_en_reg;
        flag_next = (flag_reg & ~flag_clear_i) | flag_set;
        mask_next = mask_wr_i ? mask_wdata_i : mask_reg;
    end

    // Lost flag set and masks set by backup reset
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flag_reg <= rtcal_pkg::FLAG_RESET;
            mask_reg <= rtcal_pkg::MASK_RESET;
        end
        else
        begin
            flag_reg <= flag_next;
            mask_reg <= mask_next;
        end
    end

    //------------------------------------------------------------
    // Wake request and regulator level
    //------------------------------------------------------------
    // Alarm wakes an off system; level latched per state
    always_comb
    begin
        wake_next = flag_set[rtcal_pkg::FLAG_ALARM] && is_off;
        pums_hi = (power_up_mode_select_i[3:0] >= rtcal_pkg::PUMS_HI_FIRST)
               && (power_up_mode_select_i[3:0] <= rtcal_pkg::PUMS_HI_LAST)
               && !power_up_mode_select_i[4];
        hi_next = pums_hi && is_on;
    end

    // Register wake pulse and level select
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wake_reg <= 1'b0;
            hi_reg <= 1'b0;
        end
        else
        begin
            wake_reg <= wake_next;
            hi_reg <= hi_next;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    // Interrupt only from unmasked flags
    assign irq_o = |(flag_reg & ~mask_reg);
    assign seconds_of_day_o = sec_reg;
    assign day_count_o = day_reg;
    assign alarm_seconds_o = alarm_sec_reg;
    assign alarm_day_o = alarm_day_reg;
    assign flags_o = flag_reg;
    assign mask_o = mask_reg;
    assign alarm_wake_o = wake_reg;
    // Secure clock driver kept alive off only with keepalive
    assign secure_ref_clock_en_o = is_on || secure_clock_keepalive_i;
    assign secure_ref_clock_out_o = ref_clock_i
                                 && secure_ref_clock_en_o;
    assign secure_domain_reg_en_o = 1'b1;
    assign secure_domain_reg_hi_o = hi_reg;

endmodule

// File: bench/rtcal_hostm.sv
// Host side model: time base enable and reference clock level.
// Assumes the bench clock; outputs settle on the falling edge.
`timescale 1ns/1ps
module rtcal_hostm
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    output logic      tb_en_o,
    output logic      ref_clock_o
);
    logic tog;

    // Enable every cycle out of reset keeps seconds short in cycles
    assign tb_en_o     = reset_n_i;
    assign ref_clock_o = reset_n_i & tog;

    // Reference clock level toggles once per enable
    always @(negedge clk_i)
    begin
        tog <= reset_n_i ? !tog : 1'b0;
    end
endmodule

// File: bench/rtcal_chk.sv
// Port checker for the real-time clock block.
// Assumes it is bound into rtcal_top and sees only its ports.
`timescale 1ns/1ps
module rtcal_chk
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  pwr_state_i,
    input wire logic [4:0]  power_up_mode_select_i,
    input wire logic        secure_clock_keepalive_i,
    input wire logic        clock_disable_bit_i,
    input wire logic        time_wr_i,
    input wire logic [2:0]  flag_clear_i,
    input wire logic [16:0] seconds_of_day_o,
    input wire logic [14:0] day_count_o,
    input wire logic [2:0]  flags_o,
    input wire logic [2:0]  mask_o,
    input wire logic        irq_o,
    input wire logic        alarm_wake_o,
    input wire logic        secure_ref_clock_en_o,
    input wire logic        secure_domain_reg_en_o,
    input wire logic        secure_domain_reg_hi_o
);
    logic hi_w;

    // Codes 6..9 with bit 4 clear give the high level when on
    assign hi_w = !power_up_mode_select_i[4] &&
                  power_up_mode_select_i[3:0] >= 4'h6 &&
                  power_up_mode_select_i[3:0] <= 4'h9 && !pwr_state_i[1];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    property p_reg_en;
        secure_domain_reg_en_o;
    endproperty
    a_reg_en: assert property (p_reg_en)
        else $error("regulator enable dropped");
    property p_reg_hi;
        1 |=> secure_domain_reg_hi_o == $past(hi_w);
    endproperty
    a_reg_hi: assert property (p_reg_hi)
        else $error("regulator level wrong");
    property p_keep;
        secure_ref_clock_en_o ==
            (!pwr_state_i[1] || secure_clock_keepalive_i);
    endproperty
    a_keep: assert property (p_keep)
        else $error("secure clock enable wrong");
    property p_irq;
        irq_o == |(flags_o & ~mask_o);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt line wrong");
    property p_wrap;
        seconds_of_day_o == 17'h1_517F && !time_wr_i ##1
        $changed(seconds_of_day_o) |-> seconds_of_day_o == 17'h0_0000 &&
        day_count_o == $past(day_count_o) + 15'h0001;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("seconds wrap wrong");
    property p_tick;
        $changed(seconds_of_day_o) && !$past(time_wr_i) |-> flags_o[0];
    endproperty
    a_tick: assert property (p_tick)
        else $error("tick flag missing");
    property p_lost;
        flags_o[2] && !flag_clear_i[2] |=> flags_o[2];
    endproperty
    a_lost: assert property (p_lost)
        else $error("lost flag not held");
    property p_dis;
        (clock_disable_bit_i && !time_wr_i) [*4] |->
            $stable(seconds_of_day_o);
    endproperty
    a_dis: assert property (p_dis)
        else $error("seconds moved while stopped");
    property p_wake;
        alarm_wake_o |-> pwr_state_i[1];
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake while system on");
endmodule

bind rtcal_top rtcal_chk u_chk (.clk_i, .reset_n_i, .pwr_state_i,
    .power_up_mode_select_i, .secure_clock_keepalive_i,
    .clock_disable_bit_i, .time_wr_i, .flag_clear_i, .seconds_of_day_o,
    .day_count_o, .flags_o, .mask_o, .irq_o, .alarm_wake_o,
    .secure_ref_clock_en_o, .secure_domain_reg_en_o,
    .secure_domain_reg_hi_o);

// File: bench/tb_top.sv
// Self-checking bench for the real-time clock block.
// Assumes rtcal_top, the host model and the checker compile first.
`timescale 1ns/1ps
module tb_top;
    logic        clk_i, reset_n_i, tb_en_i, ref_clock_i;
    logic [1:0]  pwr_state_i, calibration_enable_mode_i;
    logic [4:0]  power_up_mode_select_i, calibration_word_i;
    logic        secure_clock_keepalive_i, clock_disable_bit_i;
    logic        alarm_wr_i, time_wr_i, mask_wr_i, irq_o, alarm_wake_o;
    logic [16:0] alarm_sec_wdata_i, sec_wdata_i, seconds_of_day_o;
    logic [16:0] alarm_seconds_o;
    logic [14:0] alarm_day_wdata_i, day_wdata_i, day_count_o, alarm_day_o;
    logic [2:0]  mask_wdata_i, flag_clear_i, flags_o, mask_o;
    logic        secure_ref_clock_out_o, secure_ref_clock_en_o;
    logic        secure_domain_reg_en_o, secure_domain_reg_hi_o;
    int          error_cnt, cmp_count, cyc, wake_seen, t0, t1;

    rtcal_hostm host (.clk_i, .reset_n_i, .tb_en_o(tb_en_i),
        .ref_clock_o(ref_clock_i));
    rtcal_top dut (.clk_i, .reset_n_i, .tb_en_i, .ref_clock_i, .pwr_state_i,
        .power_up_mode_select_i, .secure_clock_keepalive_i,
        .clock_disable_bit_i, .calibration_word_i,
        .calibration_enable_mode_i, .alarm_wr_i, .alarm_sec_wdata_i,
        .alarm_day_wdata_i, .time_wr_i, .sec_wdata_i, .day_wdata_i,
        .mask_wr_i, .mask_wdata_i, .flag_clear_i, .seconds_of_day_o,
        .day_count_o, .alarm_seconds_o, .alarm_day_o, .flags_o, .mask_o,
        .irq_o, .alarm_wake_o, .secure_ref_clock_out_o,
        .secure_ref_clock_en_o, .secure_domain_reg_en_o,
        .secure_domain_reg_hi_o);

    //------------------------------------------------------------
    // Clock, cycle stamp, helpers
    //------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Cycle stamp and wake pulse count
    always @(posedge clk_i)
    begin
        cyc++;
        if (alarm_wake_o === 1'b1)
            wake_seen++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic exp_hi(input logic [4:0] p,
                                    input logic [1:0] s);
        return !p[4] && p[3:0] >= 4'h6 && p[3:0] <= 4'h9 && s < 2'h2;
    endfunction

    function automatic int exp_per(input logic [4:0] c,
                                   input logic [1:0] m,
                                   input logic [1:0] s);
        if (m == 2'h3 || (m == 2'h1 && s != 2'h3))
            return 32768 + $signed(c);
        return 32768;
    endfunction

    // Waits for the seconds to move, returns the cycle stamp
    task automatic wait_tick(output int t);
        logic [16:0] s0;
        int          n;
        s0 = seconds_of_day_o;
        n = 0;
        while (seconds_of_day_o === s0 && n < 40000)
        begin
            @(negedge clk_i);
            n++;
        end
        t = cyc;
    endtask

    task automatic report_and_stop();
        $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        {secure_clock_keepalive_i, clock_disable_bit_i, alarm_wr_i,
         time_wr_i, mask_wr_i, mask_wdata_i, flag_clear_i} = '0;
        {power_up_mode_select_i, alarm_sec_wdata_i} = '0;
        pwr_state_i = 2'h2;
        calibration_word_i = 5'h10;
        calibration_enable_mode_i = 2'h3;
        alarm_day_wdata_i = 15'h0008;
        sec_wdata_i = rtcal_pkg::SEC_LAST;
        day_wdata_i = 15'h0007;
        reset_n_i = 1'b0;
        t0 = $urandom(32'hc3b5_0ff1);
        repeat (20) @(negedge clk_i);
        chk(flags_o, 3'h4);
        chk(mask_o, 3'h7);
        chk({seconds_of_day_o, day_count_o}, 32'h0000_0000);
        reset_n_i = 1'b1;
        {time_wr_i, alarm_wr_i, mask_wr_i} = 3'h7;
        @(negedge clk_i);
        {time_wr_i, alarm_wr_i, mask_wr_i} = 3'h0;
        chk({alarm_seconds_o, alarm_day_o}, 32'h0000_0008);
        chk(irq_o, 1'b1);
        wait_tick(t0);
        repeat (2) @(negedge clk_i);
        chk({seconds_of_day_o, day_count_o}, 32'h0000_0008);
        chk(flags_o, 3'h7);
        chk(wake_seen, 1);
        flag_clear_i = 3'h7;
        @(negedge clk_i);
        flag_clear_i = 3'h0;
        chk({flags_o, irq_o}, 4'h0);
        for (int i = 0; i < 256; i++)
        begin
            {secure_clock_keepalive_i, pwr_state_i,
             power_up_mode_select_i} = i[7:0];
            repeat (2) @(negedge clk_i);
            chk(secure_domain_reg_hi_o,
                exp_hi(power_up_mode_select_i, pwr_state_i));
            chk(secure_ref_clock_en_o, pwr_state_i < 2'h2 ||
                secure_clock_keepalive_i);
            chk(secure_domain_reg_en_o, 1'b1);
            chk(secure_ref_clock_out_o, ref_clock_i && (pwr_state_i < 2'h2
                || secure_clock_keepalive_i));
        end
        {secure_clock_keepalive_i, pwr_state_i,
         power_up_mode_select_i} = 8'h00;
        alarm_sec_wdata_i = 17'($urandom);
        alarm_day_wdata_i = 15'($urandom) | 15'h4000;
        alarm_wr_i = 1'b1;
        @(negedge clk_i);
        alarm_wr_i = 1'b0;
        chk({alarm_seconds_o, alarm_day_o},
            {alarm_sec_wdata_i, alarm_day_wdata_i});
        wait_tick(t1);
        chk(t1 - t0, exp_per(5'h10, 2'h3, 2'h0));
        calibration_enable_mode_i = 2'h1;
        pwr_state_i = 2'h3;
        calibration_word_i = 5'($urandom);
        clock_disable_bit_i = 1'b1;
        repeat (1000) @(negedge clk_i);
        clock_disable_bit_i = 1'b0;
        wait_tick(t0);
        chk(t0 - t1, exp_per(calibration_word_i, 2'h1, 2'h3) +
            1000);
        report_and_stop();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (120000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end
endmodule
